// >>> hw/sysref_sync_pkg.sv
// shared constants and types of the sysref capture and chip sync block
package sysref_sync_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [15:0] ADDR_CLK_DIV      = 16'h010b;
    localparam logic [15:0] ADDR_CAPTURE_CTRL = 16'h0120;
    localparam logic [15:0] ADDR_IGNORE_CNT   = 16'h0121;
    localparam logic [15:0] ADDR_SKEW_WINDOW  = 16'h0122;
    localparam logic [15:0] ADDR_TS_DELAY     = 16'h0123;
    localparam logic [15:0] ADDR_MONITOR      = 16'h0128;
    localparam logic [15:0] ADDR_SYNC_MODE    = 16'h01ff;
    localparam logic [15:0] ADDR_CB_FUNC_LO   = 16'h0559;
    localparam logic [15:0] ADDR_CB_FUNC_HI   = 16'h055a;
    localparam logic [15:0] ADDR_CB_COUNT     = 16'h058f;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int DIV_LSB       = 0;
    localparam int DIV_MSB       = 3;
    localparam int MODE_LSB      = 1;
    localparam int MODE_MSB      = 2;
    localparam int CLK_EDGE_BIT  = 3;
    localparam int TRANS_BIT     = 4;
    localparam int IGN_LSB       = 0;
    localparam int IGN_MSB       = 3;
    localparam int SKEW_POS_LSB  = 0;
    localparam int SKEW_POS_MSB  = 1;
    localparam int SKEW_NEG_LSB  = 2;
    localparam int SKEW_NEG_MSB  = 3;
    localparam int SYNC_MODE_BIT = 0;
    localparam int CB_CNT_LSB    = 6;
    localparam int CB_CNT_MSB    = 7;

    // ---------------------------------------------------------------
    // reset values and codes
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_CONT     = 2'h1;
    localparam logic [1:0] MODE_NSHOT    = 2'h2;
    localparam logic [3:0] FUNC_SYSREF   = 4'h5;
    localparam logic [3:0] SETUP_GOOD    = 4'h8;
    localparam logic [3:0] HOLD_BASE     = 4'h8;
    localparam logic [7:0] MON_GOOD      = 8'h88;
    localparam int         LMFC_PERIOD   = 32;
    localparam int         NUM_CB        = 3;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic clkDiv;
        logic ddc;
        logic sigMon;
        logic link;
    } resync_t;

    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_IGNORING,
        CAP_LIVE
    } cap_state_t;

endpackage

// >>> hw/sysref_edge_monitor.sv
// sysref synchroniser, edge and transition selection, setup/hold monitor
`timescale 1ns/1ps
`default_nettype none

module sysref_edge_monitor (
    input  wire logic       sys_clk,    // system clock
    input  wire logic       nrst,       // async reset, active low
    input  wire logic       sysrefIn,   // sysref pin level
    input  wire logic       fallSel,    // 1: high-to-low is the event
    input  wire logic       lateSel,    // 1: capture on the later edge
    input  wire logic [7:0] minWidth,   // least pulse width in cycles
    output logic            capEvent,   // one-cycle capture pulse
    output logic [7:0]      monitorVal  // hold nibble, setup nibble
);

    logic       sync1_reg, sync2_reg, sync3_reg, prevLvl_reg, measuring_reg;
    logic       sync3_next, prevLvl_next, measuring_next, capEvent_next;
    logic [3:0] preCnt_reg, preCnt_next, setupV_reg, setupV_next;
    logic [7:0] postCnt_reg, postCnt_next, mon_next, deficit;
    logic       sample, lvl, edgeSeen;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        sample         = lateSel ? sync3_reg : sync2_reg;
        lvl            = sample ^ fallSel;
        edgeSeen       = lvl & ~prevLvl_reg;
        sync3_next     = sync2_reg;
        prevLvl_next   = lvl;
        capEvent_next  = edgeSeen;
        preCnt_next    = preCnt_reg;
        setupV_next    = setupV_reg;
        postCnt_next   = postCnt_reg;
        measuring_next = measuring_reg;
        mon_next       = monitorVal;
        deficit        = minWidth - postCnt_reg;
        // stable-low run before the edge gives the setup margin
        if (lvl) begin
            preCnt_next = 4'h0;
        end else if (preCnt_reg != sysref_sync_pkg::SETUP_GOOD) begin
            preCnt_next = preCnt_reg + 4'h1;
        end
        if (edgeSeen) begin
            setupV_next    = preCnt_reg;
            postCnt_next   = 8'h01;
            measuring_next = 1'b1;
        end else if (measuring_reg) begin
            if (lvl && postCnt_reg < minWidth) begin
                postCnt_next = postCnt_reg + 8'h01;
            end else begin
                measuring_next = 1'b0;
                if (setupV_reg != sysref_sync_pkg::SETUP_GOOD) begin
                    mon_next = {4'h0, setupV_reg};
                end else if (postCnt_reg < minWidth) begin
                    mon_next = {sysref_sync_pkg::HOLD_BASE + ((deficit > 8'h07) ? 4'h7
                                : deficit[3:0]), 4'h0};
                end else begin
                    mon_next = sysref_sync_pkg::MON_GOOD;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg     <= 1'b0;
            sync2_reg     <= 1'b0;
            sync3_reg     <= 1'b0;
            prevLvl_reg   <= 1'b0;
            measuring_reg <= 1'b0;
            capEvent      <= 1'b0;
            preCnt_reg    <= 4'h0;
            setupV_reg    <= 4'h0;
            postCnt_reg   <= 8'h00;
            monitorVal    <= 8'h00;
        end else begin
            sync1_reg     <= sysrefIn;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync3_next;
            prevLvl_reg   <= prevLvl_next;
            measuring_reg <= measuring_next;
            capEvent      <= capEvent_next;
            preCnt_reg    <= preCnt_next;
            setupV_reg    <= setupV_next;
            postCnt_reg   <= postCnt_next;
            monitorVal    <= mon_next;
        end
    end

endmodule

`default_nettype wire

// >>> hw/sysref_capture_sync.sv
// sysref capture state machine, divider resync and sample timestamping
//
// Contract
// - sync mode bit selects divider resync (0, default) or timestamping (1).
// - normal mode capture resyncs clock divider, downconverters, monitor, link clocks.
// - timestamp mode leaves clocks running and flags the sample on control bits.
// - timestamping only without decimation.
// - each control bit has a 4-bit function; code 5 carries the sysref flag.
// - timestamp delay shifts which sample gets the flag.
// - nonzero mode write selects input type and arms capture.
// - N-shot mode field self-clears after the qualifying transition.
// - transition bit selects rising (0) or falling (1) sysref event.
// - clock edge bit selects rising (0) or falling (1) sampling edge; here 1 takes the rising-edge sample one clock later.
// - N-shot ignores programmed number of events before acting.
// - continuous mode resyncs when capture misses the LMFC-aligned edge.
// - skew window from two 2-bit fields suppresses resync.
// - negative skew counts before phase zero, positive after.
// - monitor register shows hold and setup nibbles of the last capture.
// - hold zero with setup below eight flags a setup problem.
// - setup zero with hold above eight flags a hold problem.
// - setup eight or hold eight means a clean capture.
`timescale 1ns/1ps
`default_nettype none

module sysref_capture_sync #(
    parameter int LMFC_CYCLES = sysref_sync_pkg::LMFC_PERIOD  // S times K
) (
    input  wire logic                     sys_clk,      // 200 MHz clock
    input  wire logic                     nrst,         // async reset, low
    input  wire logic                     sysrefIn,     // sysref pin
    input  wire logic                     decimationOn, // datapath decimates
    input  wire logic                     regWrEn,      // register write
    input  wire logic                     regRdEn,      // register read
    input  wire logic [15:0]              regAddr,      // register address
    input  wire logic [7:0]               regWrData,    // write data
    output logic [7:0]                    regRdData,    // read data
    output sysref_sync_pkg::resync_t      resyncOut,    // resync pulses
    output logic [sysref_sync_pkg::NUM_CB-1:0] ctrlBits, // sample ctrl bits
    output logic                          captureArmed  // capture armed
);

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    logic [7:0] clkDiv_reg, capCtrl_reg, ignCnt_reg, skew_reg, tsDelay_reg;
    logic [7:0] syncMode_reg, cbLo_reg, cbHi_reg, cbCount_reg;
    logic [7:0] clkDiv_next, capCtrl_next, ignCnt_next, skew_next;
    logic [7:0] tsDelay_next, syncMode_next, cbLo_next, cbHi_next;
    logic [7:0] cbCount_next, rdData_next;
    logic [7:0] monitorVal, minWidth;
    logic [3:0] divCode;
    logic [1:0] modeField;
    logic       capEvent, selfClear;

    assign modeField = capCtrl_reg[sysref_sync_pkg::MODE_MSB:sysref_sync_pkg::MODE_LSB];
    assign divCode   = clkDiv_reg[sysref_sync_pkg::DIV_MSB:sysref_sync_pkg::DIV_LSB];
    // code 0 is divide by 1; the source must hold two clocks per divided period
    // one spare bit keeps divide by 16 from wrapping to zero
    assign minWidth  = {2'h0, {1'b0, divCode} + 5'h01, 1'b0};

    sysref_edge_monitor i_sysref_edge_monitor (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .sysrefIn   (sysrefIn),
        .fallSel    (capCtrl_reg[sysref_sync_pkg::TRANS_BIT]),
        .lateSel    (capCtrl_reg[sysref_sync_pkg::CLK_EDGE_BIT]),
        .minWidth   (minWidth),
        .capEvent   (capEvent),
        .monitorVal (monitorVal)
    );

    always_comb begin
        clkDiv_next   = clkDiv_reg;
        capCtrl_next  = capCtrl_reg;
        ignCnt_next   = ignCnt_reg;
        skew_next     = skew_reg;
        tsDelay_next  = tsDelay_reg;
        syncMode_next = syncMode_reg;
        cbLo_next     = cbLo_reg;
        cbHi_next     = cbHi_reg;
        cbCount_next  = cbCount_reg;
        // a software write in the same cycle wins over the self-clear
        if (selfClear) begin
            capCtrl_next[sysref_sync_pkg::MODE_MSB:sysref_sync_pkg::MODE_LSB]
                = sysref_sync_pkg::MODE_OFF;
        end
        if (regWrEn) begin
            unique case (regAddr)
                sysref_sync_pkg::ADDR_CLK_DIV:      clkDiv_next   = regWrData;
                sysref_sync_pkg::ADDR_CAPTURE_CTRL: capCtrl_next  = regWrData;
                sysref_sync_pkg::ADDR_IGNORE_CNT:   ignCnt_next   = regWrData;
                sysref_sync_pkg::ADDR_SKEW_WINDOW:  skew_next     = regWrData;
                sysref_sync_pkg::ADDR_TS_DELAY:     tsDelay_next  = regWrData;
                sysref_sync_pkg::ADDR_SYNC_MODE:    syncMode_next = regWrData;
                sysref_sync_pkg::ADDR_CB_FUNC_LO:   cbLo_next     = regWrData;
                sysref_sync_pkg::ADDR_CB_FUNC_HI:   cbHi_next     = regWrData;
                sysref_sync_pkg::ADDR_CB_COUNT:     cbCount_next  = regWrData;
                default:                            clkDiv_next   = clkDiv_reg;
            endcase
        end
        rdData_next = regRdData;
        if (regRdEn) begin
            unique case (regAddr)
                sysref_sync_pkg::ADDR_CLK_DIV:      rdData_next = clkDiv_reg;
                sysref_sync_pkg::ADDR_CAPTURE_CTRL: rdData_next = capCtrl_reg;
                sysref_sync_pkg::ADDR_IGNORE_CNT:   rdData_next = ignCnt_reg;
                sysref_sync_pkg::ADDR_SKEW_WINDOW:  rdData_next = skew_reg;
                sysref_sync_pkg::ADDR_TS_DELAY:     rdData_next = tsDelay_reg;
                sysref_sync_pkg::ADDR_MONITOR:      rdData_next = monitorVal;
                sysref_sync_pkg::ADDR_SYNC_MODE:    rdData_next = syncMode_reg;
                sysref_sync_pkg::ADDR_CB_FUNC_LO:   rdData_next = cbLo_reg;
                sysref_sync_pkg::ADDR_CB_FUNC_HI:   rdData_next = cbHi_reg;
                sysref_sync_pkg::ADDR_CB_COUNT:     rdData_next = cbCount_reg;
                default:                            rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clkDiv_reg   <= sysref_sync_pkg::RST_REG;
            capCtrl_reg  <= sysref_sync_pkg::RST_REG;
            ignCnt_reg   <= sysref_sync_pkg::RST_REG;
            skew_reg     <= sysref_sync_pkg::RST_REG;
            tsDelay_reg  <= sysref_sync_pkg::RST_REG;
            syncMode_reg <= sysref_sync_pkg::RST_REG;
            cbLo_reg     <= sysref_sync_pkg::RST_REG;
            cbHi_reg     <= sysref_sync_pkg::RST_REG;
            cbCount_reg  <= sysref_sync_pkg::RST_REG;
            regRdData    <= 8'h00;
        end else begin
            clkDiv_reg   <= clkDiv_next;
            capCtrl_reg  <= capCtrl_next;
            ignCnt_reg   <= ignCnt_next;
            skew_reg     <= skew_next;
            tsDelay_reg  <= tsDelay_next;
            syncMode_reg <= syncMode_next;
            cbLo_reg     <= cbLo_next;
            cbHi_reg     <= cbHi_next;
            cbCount_reg  <= cbCount_next;
            regRdData    <= rdData_next;
        end
    end

    // ---------------------------------------------------------------
    // capture state machine and lmfc phase
    // ---------------------------------------------------------------
    sysref_sync_pkg::cap_state_t state_reg, state_next;
    logic [3:0] ignLeft_reg, ignLeft_next;
    logic [7:0] lmfcPhase_reg, lmfcPhase_next, tsCnt_reg, tsCnt_next;
    logic [7:0] negWin, posWin;
    logic       tsPending_reg, tsPending_next, tsFlag, armWrite;
    logic       act, inWindow, doResync, doStamp;
    sysref_sync_pkg::resync_t resync_next;
    logic [sysref_sync_pkg::NUM_CB-1:0] ctrl_next;
    logic [3:0] cbFunc [sysref_sync_pkg::NUM_CB];
    logic [1:0] cbCount;

    assign negWin  = {6'h00,
                      skew_reg[sysref_sync_pkg::SKEW_NEG_MSB:sysref_sync_pkg::SKEW_NEG_LSB]};
    assign posWin  = {6'h00,
                      skew_reg[sysref_sync_pkg::SKEW_POS_MSB:sysref_sync_pkg::SKEW_POS_LSB]};
    assign cbCount = cbCount_reg[sysref_sync_pkg::CB_CNT_MSB:sysref_sync_pkg::CB_CNT_LSB];
    assign cbFunc[0] = cbLo_reg[3:0];
    assign cbFunc[1] = cbLo_reg[7:4];
    assign cbFunc[2] = cbHi_reg[3:0];
    // changing bit 4 while arming can raise a false edge; set it first
    assign armWrite  = regWrEn && regAddr == sysref_sync_pkg::ADDR_CAPTURE_CTRL;

    always_comb begin
        state_next     = state_reg;
        ignLeft_next   = ignLeft_reg;
        lmfcPhase_next = (lmfcPhase_reg == 8'(LMFC_CYCLES - 1)) ? 8'h00
                         : lmfcPhase_reg + 8'h01;
        tsCnt_next     = tsCnt_reg;
        tsPending_next = tsPending_reg;
        resync_next    = '0;
        selfClear      = 1'b0;
        act            = 1'b0;
        doResync       = 1'b0;
        doStamp        = 1'b0;
        tsFlag         = 1'b0;
        // before phase zero counts as negative skew, after it as positive
        inWindow = (lmfcPhase_reg <= posWin) ||
                   (lmfcPhase_reg >= 8'(LMFC_CYCLES) - negWin);
        unique case (state_reg)
            sysref_sync_pkg::CAP_IDLE: begin
            end
            sysref_sync_pkg::CAP_IGNORING: begin
                if (capEvent) begin
                    ignLeft_next = ignLeft_reg - 4'h1;
                    if (ignLeft_reg == 4'h1) begin
                        state_next = sysref_sync_pkg::CAP_LIVE;
                    end
                end
            end
            sysref_sync_pkg::CAP_LIVE: begin
                if (capEvent) begin
                    act = 1'b1;
                    if (modeField == sysref_sync_pkg::MODE_NSHOT) begin
                        selfClear  = 1'b1;
                        state_next = sysref_sync_pkg::CAP_IDLE;
                    end
                end
            end
        endcase
        // any write of the mode field re-arms or disarms the machine
        if (armWrite) begin
            // count comes from its own register, latched on each arming write
            ignLeft_next = ignCnt_reg[sysref_sync_pkg::IGN_MSB:sysref_sync_pkg::IGN_LSB];
            if (regWrData[sysref_sync_pkg::MODE_MSB:sysref_sync_pkg::MODE_LSB]
                    == sysref_sync_pkg::MODE_OFF) begin
                state_next = sysref_sync_pkg::CAP_IDLE;
            end else if (regWrData[sysref_sync_pkg::MODE_MSB:sysref_sync_pkg::MODE_LSB]
                    == sysref_sync_pkg::MODE_NSHOT && ignLeft_next != 4'h0) begin
                state_next = sysref_sync_pkg::CAP_IGNORING;
            end else begin
                state_next = sysref_sync_pkg::CAP_LIVE;
            end
        end
        if (act) begin
            if (syncMode_reg[sysref_sync_pkg::SYNC_MODE_BIT]) begin
                doStamp = !decimationOn;
            end else if (modeField == sysref_sync_pkg::MODE_NSHOT) begin
                doResync = 1'b1;
            end else begin
                doResync = !inWindow;
            end
        end
        // restart at one: the capture cycle itself becomes phase zero
        if (doResync) begin
            resync_next    = '1;
            lmfcPhase_next = 8'h01;
        end
        // delay zero flags the capture sample itself
        if (tsPending_reg) begin
            tsCnt_next = tsCnt_reg - 8'h01;
            if (tsCnt_reg == 8'h01) begin
                tsFlag         = 1'b1;
                tsPending_next = 1'b0;
            end
        end
        // a new stamp while one is pending restarts the delay
        if (doStamp) begin
            if (tsDelay_reg == 8'h00) begin
                tsFlag = 1'b1;
            end else begin
                tsCnt_next     = tsDelay_reg;
                tsPending_next = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // control bit routing
    // ---------------------------------------------------------------

    genvar gi;
    generate
        for (gi = 0; gi < sysref_sync_pkg::NUM_CB; gi++) begin : g_cb
            // only enabled control bits set to the sysref function carry the flag
            assign ctrl_next[gi] = tsFlag && (gi < int'(cbCount)) &&
                                   cbFunc[gi] == sysref_sync_pkg::FUNC_SYSREF;
        end
    endgenerate

    // ---------------------------------------------------------------
    // output registers
    // ---------------------------------------------------------------

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= sysref_sync_pkg::CAP_IDLE;
            ignLeft_reg   <= 4'h0;
            lmfcPhase_reg <= 8'h00;
            tsCnt_reg     <= 8'h00;
            tsPending_reg <= 1'b0;
            resyncOut     <= '0;
            ctrlBits      <= '0;
            captureArmed  <= 1'b0;
        end else begin
            state_reg     <= state_next;
            ignLeft_reg   <= ignLeft_next;
            lmfcPhase_reg <= lmfcPhase_next;
            tsCnt_reg     <= tsCnt_next;
            tsPending_reg <= tsPending_next;
            resyncOut     <= resync_next;
            ctrlBits      <= ctrl_next;
            captureArmed  <= state_next != sysref_sync_pkg::CAP_IDLE;
        end
    end

endmodule

`default_nettype wire

// >>> testbench/sysref_capture_sync_chk.sv
// assertion checker for the sysref capture and chip sync block
`timescale 1ns/1ps
`default_nettype none

module sysref_capture_sync_chk (
    input wire logic                               sys_clk,      // clock
    input wire logic                               nrst,         // reset, active low
    input wire logic                               regWrEn,      // write strobe
    input wire logic [15:0]                        regAddr,      // address
    input wire logic [7:0]                         regWrData,    // write data
    input wire sysref_sync_pkg::resync_t           resyncOut,    // resync pulses
    input wire logic [sysref_sync_pkg::NUM_CB-1:0] ctrlBits,     // sample flags
    input wire logic                               captureArmed  // armed level
);
    // ---------------------------------------------------------------
    // helper logic
    // ---------------------------------------------------------------
    logic [1:0] lastMode_reg;
    logic [1:0] lastMode_next;
    wire logic  capWr = regWrEn && regAddr == sysref_sync_pkg::ADDR_CAPTURE_CTRL;

    // mode last written by software, so one-shot disarm can be told apart
    always_comb lastMode_next = capWr ? regWrData[2:1] : lastMode_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) lastMode_reg <= 2'h0;
        else lastMode_reg <= lastMode_next;
    end

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence armWr;
        capWr && regWrData[2:1] != 2'h0;
    endsequence
    sequence resyncSeen;
        resyncOut != 4'h0;
    endsequence

    AST_RESYNC_ALL: assert property (resyncSeen |-> resyncOut == 4'hf)
        else $error("resync pulse not on all four targets");
    AST_RESYNC_ONE: assert property (resyncSeen |=> resyncOut == 4'h0)
        else $error("resync pulse longer than one cycle");
    AST_FLAG_ONE: assert property (ctrlBits != 3'h0 |=> ctrlBits == 3'h0)
        else $error("timestamp flag longer than one cycle");
    AST_EXCLUSIVE: assert property (ctrlBits != 3'h0 |-> resyncOut == 4'h0)
        else $error("timestamp and resync together");
    AST_ARMED_SRC: assert property (resyncSeen |-> $past(captureArmed))
        else $error("resync while disarmed");
    AST_ARM: assert property (armWr |=> captureArmed)
        else $error("nonzero mode write did not arm");
    AST_DISARM: assert property (capWr && regWrData[2:1] == 2'h0 |=> !captureArmed)
        else $error("zero mode write left capture armed");
    AST_NSHOT_CLEAR: assert property (
        resyncSeen and (lastMode_reg == 2'h2 && !$past(capWr)) |-> !captureArmed)
        else $error("one-shot capture stayed armed");
endmodule

bind sysref_capture_sync sysref_capture_sync_chk i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .resyncOut(resyncOut), .ctrlBits(ctrlBits),
    .captureArmed(captureArmed));

`default_nettype wire

// >>> testbench/sysref_source.sv
// sysref source model standing in for the system clock generator
`timescale 1ns/1ps
`default_nettype none

module sysref_source (
    input  wire logic sys_clk, // device clock
    output logic      sysref   // sysref drive
);
    initial sysref = 1'b0;
    // width in device clocks; callers keep it at least twice the divide ratio
    task automatic pulse(input int w);
        @(posedge sys_clk);
        #1 sysref = 1'b1;
        repeat (w) @(posedge sys_clk);
        #1 sysref = 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> testbench/test_sysref_capture_sync.sv
// self-checking bench for the sysref capture and chip sync block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module test_sysref_capture_sync;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        sysrefIn;
    logic        decimationOn = 1'b0;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0]  regWrData = 8'h00;
    logic [7:0]  regRdData;
    logic [3:0]  seenR;
    logic [2:0]  seenC;
    logic [7:0]  cfg [3] = '{8'h04, 8'h14, 8'h0c};
    logic [15:0] fn [3] = '{16'h0005, 16'h0050, 16'h0500};
    int          off [3] = '{0, 4, 1};
    int          failures = 0;
    int          n_checks = 0;
    int          first;
    int          t0;
    sysref_sync_pkg::resync_t resyncOut;
    logic [2:0]  ctrlBits;
    logic        captureArmed;

    always #2.5 sys_clk = ~sys_clk;

    sysref_source i_sysref_source (.sys_clk(sys_clk), .sysref(sysrefIn));
    sysref_capture_sync i_sysref_capture_sync (.sys_clk(sys_clk), .nrst(nrst),
        .sysrefIn(sysrefIn), .decimationOn(decimationOn), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .resyncOut(resyncOut), .ctrlBits(ctrlBits),
        .captureArmed(captureArmed));

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1 regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge sys_clk) #1 regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk) #1 regRdEn = 1'b1;
        regAddr = a;
        @(posedge sys_clk) #1 regRdEn = 1'b0;
        `CHK(regRdData, e)
    endtask

    // one sysref pulse while collecting every resync and flag seen in a 40-cycle window
    task automatic shot(input int w, input logic [3:0] er, input logic [2:0] ec);
        seenR = 4'h0;
        seenC = 3'h0;
        first = -1;
        fork
            i_sysref_source.pulse(w);
            for (int i = 0; i < 40; i++) begin
                @(posedge sys_clk) #1;
                seenR |= resyncOut;
                seenC |= ctrlBits;
                if (first < 0 && (seenR != 4'h0 || seenC != 3'h0)) first = i;
            end
        join
        `CHK(seenR, er)
        `CHK(seenC, ec)
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // the tests need under a thousand cycles; this limit is ten thousand
    initial begin
        #50000;
        failures++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1 nrst = 1'b1;
        `CHK(captureArmed, 1'b0)
        rd(16'h0120, 8'h00);
        rd(16'h01ff, 8'h00);
        wr(16'h0128, 8'h55);
        rd(16'h0128, 8'h00);
        $display("test reset done");
        wr(16'h0121, 8'h02);
        wr(16'h0120, 8'h04);
        `CHK(captureArmed, 1'b1)
        shot(4, 4'h0, 3'h0);
        shot(4, 4'h0, 3'h0);
        shot(4, 4'hf, 3'h0);
        rd(16'h0120, 8'h00);
        rd(16'h0128, 8'h88);
        wr(16'h0121, 8'h00);
        $display("test ignore done");
        for (int k = 0; k < 3; k++) begin
            // edge and transition settle before arming, so no false event
            wr(16'h0120, cfg[k] & 8'hf9);
            repeat (8) @(posedge sys_clk);
            wr(16'h0120, cfg[k]);
            shot(4, 4'hf, 3'h0);
            if (k == 0) t0 = first;
            else `CHK(first - t0, off[k])
            rd(16'h0120, cfg[k] & 8'hf9);
        end
        wr(16'h0120, 8'h00);
        $display("test edges done");
        wr(16'h0120, 8'h04);
        shot(4, 4'hf, 3'h0);
        // pulses 64 clocks apart (two lmfc periods), then 40, then 62
        wr(16'h0120, 8'h02);
        repeat (22) @(posedge sys_clk);
        shot(4, 4'h0, 3'h0);
        shot(4, 4'hf, 3'h0);
        wr(16'h0122, 8'h08);
        repeat (20) @(posedge sys_clk);
        shot(4, 4'h0, 3'h0);
        wr(16'h0120, 8'h00);
        $display("test continuous done");
        wr(16'h01ff, 8'h01);
        wr(16'h058f, 8'hc0);
        for (int k = 0; k < 3; k++) begin
            wr(16'h0559, fn[k][7:0]);
            wr(16'h055a, fn[k][15:8]);
            wr(16'h0120, 8'h04);
            shot(4, 4'h0, 3'h1 << k);
        end
        t0 = first;
        wr(16'h0123, 8'h03);
        wr(16'h0120, 8'h04);
        shot(4, 4'h0, 3'h4);
        `CHK(first - t0, 3)
        $display("test timestamp done");
        @(posedge sys_clk) #1 decimationOn = 1'b1;
        wr(16'h0120, 8'h04);
        shot(4, 4'h0, 3'h0);
        $display("test decimation done");
        conclude();
    end
endmodule

`default_nettype wire
